// *** rtl/cfg_responder.sv ***
// device end: parses configuration messages, owns the register banks, answers.
// assumes one requester at a time on the link and a synchronous, active-low reset.
`timescale 1ns/100ps
`include "cfgmsg_cfg.svh"

module cfg_responder (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// link
	cfgmsg_if.responder      lk,
	// processor status access
	input  wire logic        ps_valid,
	input  wire logic        ps_write,
	input  wire logic [7:0]  ps_num,
	input  wire logic [31:0] ps_wdata,
	output logic      [31:0] ps_rdata,
	output logic      [31:0] ps_resource,
	// peripheral side fill of its readable bytes
	input  wire logic        periph_wr,
	input  wire logic [`CFG_PB_W-1:0] periph_addr,
	input  wire logic [7:0]  periph_wdata
);

	cfgmsg_pkg::resp_s s;
	cfgmsg_pkg::resp_s next_s;

	// ============================================================
	// helpers
	function automatic cfgmsg_pkg::bank_e bank_of(input logic [31:0] dest);
		if (dest[15:0] == `CFG_DEST_TILE)
			return cfgmsg_pkg::BK_TILE;
		else if (dest[15:0] == `CFG_DEST_NODE)
			return cfgmsg_pkg::BK_NODE;
		else if (dest[7:0] == `CFG_DEST_PERIPH)
			return cfgmsg_pkg::BK_PERIPH;
		return cfgmsg_pkg::BK_NONE;
	endfunction

	function automatic logic [3:0] need_of(input cfgmsg_pkg::op_e op);
		return (op == cfgmsg_pkg::OP_WRITE) ? `CFG_LEN_WRITE : `CFG_LEN_READ;
	endfunction

	// token number i of the answer, built from the latched outcome
	function automatic logic [8:0] token_at(input cfgmsg_pkg::resp_s st, input logic [4:0] i);
		logic [`CFG_PB_W-1:0] pa;
		pa = st.pbase + `CFG_PB_W'(i - 5'h01);
		if (i == 5'h00)
			return {1'b1, st.ok ? `CFG_TOK_ACK : `CFG_TOK_NACK};
		else if (i == st.len - 5'h01)
			return {1'b1, `CFG_TOK_END};
		else if (st.op == cfgmsg_pkg::OP_READ)
			return {1'b0, 8'(st.rword >> (8 * (4 - i)))};
		return {1'b0, st.periph[pa]};
	endfunction

	// ============================================================
	// outputs; ready only while a message is being taken in
	assign lk.req_ready = (s.state == cfgmsg_pkg::RS_IDLE) ||
	                      (s.state == cfgmsg_pkg::RS_BODY) ||
	                      (s.state == cfgmsg_pkg::RS_DRAIN);
	assign lk.rsp_valid = s.rsp_valid;
	assign lk.rsp_ctrl  = s.rsp_ctrl;
	assign lk.rsp_data  = s.rsp_data;
	assign lk.rsp_dest  = s.rsp_dest;
	assign ps_rdata     = s.ps_rdata;
	assign ps_resource  = s.ps_resource;

	// ============================================================
	// next state
	always_comb begin
		logic [23:0]  reply;
		logic [15:0]  rnum;
		logic [31:0]  wdata;
		logic [8:0]   pend;
		logic         ok;
		logic [8:0]   tok;
		next_s = s;
		reply  = '0;
		rnum   = '0;
		wdata  = '0;
		pend   = '0;
		ok     = 1'b0;
		tok    = '0;

		// processor status path runs beside the message engine
		if (ps_valid) begin
			next_s.ps_resource = (32'(ps_num) << `CFG_PS_SHIFT) | `CFG_PS_CODE; // [R10]
			if (ps_num < 8'(`CFG_PS_REGS)) begin
				if (ps_write)
					next_s.ps[ps_num[2:0]] = ps_wdata; // [R11] [R12]
				next_s.ps_rdata = s.ps[ps_num[2:0]]; // [R11]
			end else begin
				next_s.ps_rdata = '0;
			end
		end

		// peripheral owns its byte store; link can only read it
		if (periph_wr)
			next_s.periph[periph_addr] = periph_wdata;

		unique case (s.state)
			cfgmsg_pkg::RS_IDLE: begin
				if (lk.req_valid) begin
					next_s.bank = bank_of(lk.req_dest);
					next_s.cnt  = '0;
					next_s.body = '0;
					next_s.bad  = 1'b0;
					// peripheral select comes from the destination, not the reply id
					next_s.pbase = `CFG_PB_W'({lk.req_dest[9:8], 4'h0}); // [R7]
					if (!lk.req_ctrl) begin
						// data with no header: swallow to the end token
						next_s.op    = cfgmsg_pkg::OP_BAD;
						next_s.state = cfgmsg_pkg::RS_DRAIN; // [R14]
					end else if (lk.req_data == `CFG_TOK_WRITE) begin
						next_s.op    = cfgmsg_pkg::OP_WRITE; // [R1]
						next_s.state = cfgmsg_pkg::RS_BODY;
					end else if (lk.req_data == `CFG_TOK_READ) begin
						next_s.op    = cfgmsg_pkg::OP_READ; // [R3]
						next_s.state = cfgmsg_pkg::RS_BODY;
					end else if (lk.req_data == `CFG_TOK_PREAD) begin
						next_s.op    = cfgmsg_pkg::OP_PREAD; // [R8]
						next_s.state = cfgmsg_pkg::RS_BODY;
					end else begin
						next_s.op    = cfgmsg_pkg::OP_BAD;
						next_s.state = (lk.req_data == `CFG_TOK_END) ?
						               cfgmsg_pkg::RS_EXEC : cfgmsg_pkg::RS_DRAIN; // [R14]
					end
				end
			end
			cfgmsg_pkg::RS_BODY: begin
				if (lk.req_valid) begin
					if (lk.req_ctrl) begin
						// short body or a stray control token both fail
						next_s.bad   = (lk.req_data != `CFG_TOK_END) ||
						               (s.cnt != need_of(s.op)); // [R14]
						next_s.state = (lk.req_data == `CFG_TOK_END) ?
						               cfgmsg_pkg::RS_EXEC : cfgmsg_pkg::RS_DRAIN;
					end else if (s.cnt == need_of(s.op)) begin
						next_s.bad   = 1'b1; // [R14]
						next_s.state = cfgmsg_pkg::RS_DRAIN;
					end else begin
						next_s.body = {s.body[63:0], lk.req_data}; // [R1] [R3] [R8]
						next_s.cnt  = s.cnt + 4'h1;
					end
				end
			end
			cfgmsg_pkg::RS_DRAIN: begin
				next_s.bad = 1'b1;
				if (lk.req_valid && lk.req_ctrl && lk.req_data == `CFG_TOK_END)
					next_s.state = cfgmsg_pkg::RS_EXEC;
			end
			cfgmsg_pkg::RS_EXEC: begin
				// field positions follow the body length of each message kind
				if (s.op == cfgmsg_pkg::OP_WRITE) begin
					reply = s.body[71:48];
					rnum  = s.body[47:32];
					wdata = s.body[31:0];
				end else begin
					reply = s.body[39:16];
					rnum  = s.body[15:0];
				end
				pend = 9'(rnum[15:8]) + 9'(rnum[7:0]);
				unique case (s.op)
					cfgmsg_pkg::OP_WRITE, cfgmsg_pkg::OP_READ:
						ok = !s.bad && (s.bank == cfgmsg_pkg::BK_TILE ||
						     s.bank == cfgmsg_pkg::BK_NODE) &&
						     rnum < 16'(`CFG_WORD_REGS); // [R12] [R14]
					cfgmsg_pkg::OP_PREAD:
						ok = !s.bad && s.bank == cfgmsg_pkg::BK_PERIPH &&
						     rnum[7:0] != 8'h00 &&
						     pend <= 9'(`CFG_PERIPH_BYTES); // [R9] [R14]
					cfgmsg_pkg::OP_BAD:
						ok = 1'b0; // [R14]
				endcase
				// only a fully checked write touches a bank
				if (ok && s.op == cfgmsg_pkg::OP_WRITE) begin
					if (s.bank == cfgmsg_pkg::BK_TILE)
						next_s.tile[rnum[`CFG_WIDX_W-1:0]] = wdata; // [R1]
					else
						next_s.node[rnum[`CFG_WIDX_W-1:0]] = wdata; // [R1]
				end
				next_s.rword = (s.bank == cfgmsg_pkg::BK_TILE) ?
				               s.tile[rnum[`CFG_WIDX_W-1:0]] :
				               s.node[rnum[`CFG_WIDX_W-1:0]];
				next_s.pbase = {s.pbase[`CFG_PB_W-1:4], rnum[11:8]}; // [R7]
				next_s.ok    = ok;
				if (!ok || s.op == cfgmsg_pkg::OP_WRITE)
					next_s.len = 5'h02; // [R2] [R14]
				else if (s.op == cfgmsg_pkg::OP_READ)
					next_s.len = 5'h06; // [R4]
				else
					next_s.len = 5'(rnum[7:0]) + 5'h02; // [R9]
				next_s.idx       = '0;
				next_s.rsp_dest  = reply; // [R13]
				next_s.rsp_valid = 1'b1;
				next_s.rsp_ctrl  = 1'b1;
				next_s.rsp_data  = ok ? `CFG_TOK_ACK : `CFG_TOK_NACK; // [R2] [R4] [R9]
				next_s.state     = cfgmsg_pkg::RS_REPLY;
			end
			cfgmsg_pkg::RS_REPLY: begin
				if (lk.rsp_ready) begin
					if (s.idx == s.len - 5'h01) begin
						next_s.rsp_valid = 1'b0;
						next_s.state     = cfgmsg_pkg::RS_IDLE;
					end else begin
						tok              = token_at(s, s.idx + 5'h01); // [R2] [R4] [R9]
						next_s.idx       = s.idx + 5'h01;
						next_s.rsp_ctrl  = tok[8];
						next_s.rsp_data  = tok[7:0];
					end
				end
			end
		endcase
	end

	// ============================================================
	// state register; banks clear to zero on reset
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

// *** shared/cfgmsg_cfg.svh ***
// constants for the configuration message link: token codes, destination codes,
// message lengths and the sizes of the register banks behind the responder.
// assumes the link carries one 9-bit token (control flag plus byte) per handshake.
// Operation
// R1: write: 192, reply id, reg16, data32, end
// R2: write answer: 3 then 1, or 4 then 1
// R3: read: 193, reply id, reg16, end
// R4: read answer: 3, word, 1; or 4, 1
// R5: tile destination ends in C20C
// R6: node destination: node id, low C30C
// R7: peripheral destination: node, peripheral, low 02
// R8: peripheral read: 37, reply id, reg8, size8, end
// R9: peripheral answer: 3, bytes, 1; or 4, 1
// R10: status resource id is number<<8 or 0x0C
// R11: status access moves one whole word
// R12: separate banks, each with its own path
// R13: answer goes to the request's reply id
// R14: bad number or message: 4, 1, nothing changes
`ifndef CFGMSG_CFG_SVH
`define CFGMSG_CFG_SVH

// ============================================================
// tokens
`define CFG_TOK_WRITE   8'hC0
`define CFG_TOK_READ    8'hC1
`define CFG_TOK_PREAD   8'h25
`define CFG_TOK_ACK     8'h03
`define CFG_TOK_NACK    8'h04
`define CFG_TOK_END     8'h01

// ============================================================
// destination low-order codes
`define CFG_DEST_TILE   16'hC20C
`define CFG_DEST_NODE   16'hC30C
`define CFG_DEST_PERIPH 8'h02
`define CFG_PS_CODE     32'h0000000C
`define CFG_PS_SHIFT    8

// ============================================================
// message body lengths in bytes, bank sizes
`define CFG_LEN_WRITE   4'h9
`define CFG_LEN_READ    4'h5
`define CFG_WORD_REGS   8
`define CFG_WIDX_W      3
`define CFG_PS_REGS     8
`define CFG_PERIPH_N    4
`define CFG_PERIPH_BYTES 16
`define CFG_PB_W        6

`endif

// *** shared/cfgmsg_pkg.sv ***
// types shared by the requester and responder ends of the configuration link.
// assumes cfgmsg_cfg.svh is on the include path.
`include "cfgmsg_cfg.svh"

package cfgmsg_pkg;

	// ============================================================
	// responder
	typedef enum logic [2:0] {RS_IDLE, RS_BODY, RS_DRAIN, RS_EXEC, RS_REPLY} resp_state_e;
	typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PREAD, OP_BAD} op_e;
	typedef enum logic [1:0] {BK_TILE, BK_NODE, BK_PERIPH, BK_NONE} bank_e;

	typedef struct packed {
		resp_state_e                            state;
		op_e                                    op;
		bank_e                                  bank;
		logic [71:0]                            body;
		logic [3:0]                             cnt;
		logic                                   bad;
		logic                                   ok;
		logic [4:0]                             idx;
		logic [4:0]                             len;
		logic [31:0]                            rword;
		logic [`CFG_PB_W-1:0]                   pbase;
		logic                                   rsp_valid;
		logic                                   rsp_ctrl;
		logic [7:0]                             rsp_data;
		logic [23:0]                            rsp_dest;
		logic [`CFG_WORD_REGS-1:0][31:0]        tile;
		logic [`CFG_WORD_REGS-1:0][31:0]        node;
		logic [`CFG_PS_REGS-1:0][31:0]          ps;
		logic [`CFG_PERIPH_N*`CFG_PERIPH_BYTES-1:0][7:0] periph;
		logic [31:0]                            ps_rdata;
		logic [31:0]                            ps_resource;
	} resp_s;

	// ============================================================
	// requester
	typedef enum logic [2:0] {QS_IDLE, QS_HEAD, QS_BODY, QS_END, QS_STATUS, QS_DATA} req_state_e;
	typedef enum logic [2:0] {K_TILE_WR, K_TILE_RD, K_NODE_WR, K_NODE_RD, K_PERIPH_RD} kind_e;

	typedef struct packed {
		req_state_e  state;
		logic [7:0]  head;
		logic [71:0] body;
		logic [3:0]  cnt;
		logic [3:0]  len;
		logic [31:0] dest;
		logic        ok;
		logic [31:0] rdata;
		logic        done;
	} req_s;

endpackage

// *** shared/cfgmsg_if.sv ***
// token link between a configuration requester and the responder.
// assumes both ends share core_clk; each direction is a valid/ready token stream.
`timescale 1ns/100ps

interface cfgmsg_if;
	// requester to responder
	logic        req_valid;
	logic        req_ready;
	logic        req_ctrl;
	logic [7:0]  req_data;
	logic [31:0] req_dest;
	// responder to requester
	logic        rsp_valid;
	logic        rsp_ready;
	logic        rsp_ctrl;
	logic [7:0]  rsp_data;
	logic [23:0] rsp_dest;

	modport responder (
		input  req_valid, req_ctrl, req_data, req_dest, rsp_ready,
		output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
	);
	modport requester (
		output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
		input  req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
	);
endinterface

// *** rtl/cfg_requester.sv ***
// far end: turns a user command into a configuration message and collects the answer.
// assumes the responder sits on the same core_clk and answers on the return stream.
`timescale 1ns/100ps
`include "cfgmsg_cfg.svh"

module cfg_requester (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	// link
	cfgmsg_if.requester       lk,
	// command
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire cfgmsg_pkg::kind_e cmd_kind,
	input  wire logic [15:0]  cmd_target,
	input  wire logic [7:0]   cmd_periph,
	input  wire logic [23:0]  cmd_reply,
	input  wire logic [15:0]  cmd_reg,
	input  wire logic [31:0]  cmd_wdata,
	input  wire logic [7:0]   cmd_size,
	// result
	output logic              res_done,
	output logic              res_ok,
	output logic      [31:0]  res_rdata
);

	cfgmsg_pkg::req_s q;
	cfgmsg_pkg::req_s next_q;

	// ============================================================
	// destination formed from the target kind
	function automatic logic [31:0] dest_of(input cfgmsg_pkg::kind_e k,
	                                        input logic [15:0] id, input logic [7:0] pp);
		if (k == cfgmsg_pkg::K_TILE_WR || k == cfgmsg_pkg::K_TILE_RD)
			return {id, `CFG_DEST_TILE}; // [R5]
		else if (k == cfgmsg_pkg::K_PERIPH_RD)
			return {id, pp, `CFG_DEST_PERIPH}; // [R7]
		return {id, `CFG_DEST_NODE}; // [R6]
	endfunction

	// ============================================================
	// link drive straight from state flops
	assign cmd_ready    = (q.state == cfgmsg_pkg::QS_IDLE);
	assign lk.req_valid = (q.state == cfgmsg_pkg::QS_HEAD) ||
	                      (q.state == cfgmsg_pkg::QS_BODY) ||
	                      (q.state == cfgmsg_pkg::QS_END);
	assign lk.req_ctrl  = (q.state != cfgmsg_pkg::QS_BODY);
	assign lk.req_data  = (q.state == cfgmsg_pkg::QS_HEAD) ? q.head :
	                      (q.state == cfgmsg_pkg::QS_BODY) ? q.body[71:64] : `CFG_TOK_END;
	assign lk.req_dest  = q.dest;
	assign lk.rsp_ready = (q.state == cfgmsg_pkg::QS_STATUS) ||
	                      (q.state == cfgmsg_pkg::QS_DATA);
	assign res_done     = q.done;
	assign res_ok       = q.ok;
	assign res_rdata    = q.rdata;

	// ============================================================
	// next state
	always_comb begin
		next_q      = q;
		next_q.done = 1'b0;
		unique case (q.state)
			cfgmsg_pkg::QS_IDLE: begin
				if (cmd_valid) begin
					next_q.dest = dest_of(cmd_kind, cmd_target, cmd_periph);
					unique case (cmd_kind)
						cfgmsg_pkg::K_TILE_WR, cfgmsg_pkg::K_NODE_WR: begin
							next_q.head = `CFG_TOK_WRITE;
							next_q.body = {cmd_reply, cmd_reg, cmd_wdata}; // [R1]
							next_q.len  = `CFG_LEN_WRITE;
						end
						cfgmsg_pkg::K_TILE_RD, cfgmsg_pkg::K_NODE_RD: begin
							next_q.head = `CFG_TOK_READ;
							next_q.body = {cmd_reply, cmd_reg, 32'h00000000}; // [R3]
							next_q.len  = `CFG_LEN_READ;
						end
						default: begin
							next_q.head = `CFG_TOK_PREAD;
							next_q.body = {cmd_reply, cmd_reg[7:0], cmd_size,
							               32'h00000000}; // [R8]
							next_q.len  = `CFG_LEN_READ;
						end
					endcase
					next_q.cnt   = '0;
					next_q.state = cfgmsg_pkg::QS_HEAD;
				end
			end
			cfgmsg_pkg::QS_HEAD: begin
				if (lk.req_ready)
					next_q.state = cfgmsg_pkg::QS_BODY;
			end
			cfgmsg_pkg::QS_BODY: begin
				// most significant byte first
				if (lk.req_ready) begin
					next_q.body = {q.body[63:0], 8'h00};
					next_q.cnt  = q.cnt + 4'h1;
					if (q.cnt == q.len - 4'h1)
						next_q.state = cfgmsg_pkg::QS_END;
				end
			end
			cfgmsg_pkg::QS_END: begin
				if (lk.req_ready)
					next_q.state = cfgmsg_pkg::QS_STATUS;
			end
			cfgmsg_pkg::QS_STATUS: begin
				if (lk.rsp_valid) begin
					next_q.ok    = lk.rsp_ctrl && lk.rsp_data == `CFG_TOK_ACK; // [R2] [R4]
					next_q.rdata = '0;
					next_q.state = cfgmsg_pkg::QS_DATA;
				end
			end
			cfgmsg_pkg::QS_DATA: begin
				// end token closes every answer; longer reads keep the last four bytes
				if (lk.rsp_valid) begin
					if (lk.rsp_ctrl) begin
						next_q.done  = 1'b1;
						next_q.state = cfgmsg_pkg::QS_IDLE;
					end else begin
						next_q.rdata = {q.rdata[23:0], lk.rsp_data}; // [R4] [R9]
					end
				end
			end
			default: next_q.state = cfgmsg_pkg::QS_IDLE;
		endcase
	end

	// ============================================================
	// state register
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			q <= '0;
		else
			q <= next_q;
	end

endmodule

// *** dv/cfgmsg_chk.sv ***
// checker for the link between the configuration requester and responder.
// assumes every link signal is sampled on core_clk and reset_n is synchronous, active low.
`timescale 1ns/100ps
`include "cfgmsg_cfg.svh"

module cfgmsg_chk (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset_n,
	// request stream
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_ctrl,
	input wire logic [7:0]  req_data,
	input wire logic [31:0] req_dest,
	// answer stream
	input wire logic        rsp_valid,
	input wire logic        rsp_ready,
	input wire logic        rsp_ctrl,
	input wire logic [7:0]  rsp_data,
	input wire logic [23:0] rsp_dest
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// ============================================================
	// message tracking
	logic        req_take;
	logic        rsp_take;
	logic        rsp_end;
	logic [7:0]  hdr;
	logic [3:0]  bcnt;
	logic [23:0] reply;
	logic [7:0]  size;
	logic        ack;
	logic [7:0]  rcnt;
	assign req_take = req_valid && req_ready;
	assign rsp_take = rsp_valid && rsp_ready;
	assign rsp_end  = rsp_take && rsp_ctrl && rsp_data == `CFG_TOK_END;

	// header restarts the body count; first three bytes are the reply id, fifth the size
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			hdr   <= 8'h00;
			bcnt  <= 4'h0;
			reply <= 24'h000000;
			size  <= 8'h00;
			ack   <= 1'b0;
			rcnt  <= 8'h00;
		end else begin
			if (req_take && req_ctrl && req_data != `CFG_TOK_END) begin
				hdr  <= req_data;
				bcnt <= 4'h0;
			end else if (req_take && !req_ctrl) begin
				bcnt <= bcnt + 4'h1;
				if (bcnt < 4'h3)
					reply <= {reply[15:0], req_data};
				if (bcnt == 4'h4)
					size <= req_data;
			end
			if (rsp_take && rsp_ctrl && rsp_data != `CFG_TOK_END) begin
				ack  <= rsp_data == `CFG_TOK_ACK;
				rcnt <= 8'h00;
			end else if (rsp_take && !rsp_ctrl) begin
				rcnt <= rcnt + 8'h01;
			end
		end
	end

	// ============================================================
	// assertions
	AST_REQ_HOLD: assert property (req_valid && !req_ready |=>
		req_valid && $stable(req_ctrl) && $stable(req_data) && $stable(req_dest))
		else $error("request token changed before it was taken");
	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_ctrl) && $stable(rsp_data))
		else $error("answer token changed before it was taken");
	AST_RSP_HEAD: assert property ($rose(rsp_valid) |->
		rsp_ctrl && (rsp_data == `CFG_TOK_ACK || rsp_data == `CFG_TOK_NACK))
		else $error("answer does not open with a status token");
	AST_NACK_END: assert property (rsp_take && rsp_ctrl && rsp_data == `CFG_TOK_NACK |=>
		rsp_valid && rsp_ctrl && rsp_data == `CFG_TOK_END)
		else $error("failure token not followed by end token");
	AST_ANSWER_TIME: assert property (req_take && req_ctrl && req_data == `CFG_TOK_END |->
		##2 rsp_valid && rsp_ctrl)
		else $error("answer not started two cycles after end token");
	AST_NO_OVERLAP: assert property (rsp_valid |-> !req_ready)
		else $error("request accepted while an answer is pending");
	AST_REPLY_DEST: assert property (rsp_valid |-> rsp_dest == reply)
		else $error("answer not sent to the requested reply id");
	AST_READ_WORD: assert property (rsp_end && ack && hdr == `CFG_TOK_READ |->
		rcnt == 8'h04)
		else $error("read answer does not carry four data bytes");
	AST_BARE_END: assert property (rsp_end && (!ack || hdr == `CFG_TOK_WRITE) |->
		rcnt == 8'h00)
		else $error("write or failure answer carries data");
	AST_PREAD_BYTES: assert property (rsp_end && ack && hdr == `CFG_TOK_PREAD |->
		rcnt == size)
		else $error("peripheral answer byte count differs from size");
	AST_BODY_LEN: assert property (req_take && req_ctrl && req_data == `CFG_TOK_END |->
		bcnt == (hdr == `CFG_TOK_WRITE ? `CFG_LEN_WRITE : `CFG_LEN_READ))
		else $error("request body length wrong for its header");
	AST_DEST_CODE: assert property (req_take && req_ctrl && req_data != `CFG_TOK_END |->
		(req_data == `CFG_TOK_PREAD ? req_dest[7:0] == `CFG_DEST_PERIPH :
		req_dest[15:0] == `CFG_DEST_TILE || req_dest[15:0] == `CFG_DEST_NODE))
		else $error("destination low code does not match the header");
endmodule

// *** dv/config_register_message_handler_bench.sv ***
// bench joining requester and responder; random and corner configuration accesses.
// assumes both ends on core_clk; inputs driven at the falling edge.
`timescale 1ns/100ps
`include "cfgmsg_cfg.svh"

module config_register_message_handler_bench;
	logic              core_clk, reset_n, cmd_valid, cmd_ready, res_done, res_ok;
	logic              ps_valid, ps_write, periph_wr;
	cfgmsg_pkg::kind_e cmd_kind;
	logic [15:0]       cmd_target, cmd_reg;
	logic [7:0]        cmd_periph, cmd_size, ps_num, periph_wdata;
	logic [23:0]       cmd_reply;
	logic [31:0]       cmd_wdata, ps_wdata, ps_rdata, ps_resource, res_rdata, lfsr, v;
	logic [5:0]        periph_addr;
	logic [31:0]       tile_m[8], node_m[8], ps_m[8];
	logic [7:0]        pb_m[16];
	cfgmsg_pkg::kind_e kt[5];
	int                error_cnt, total_checks, i;

	// ============================================================
	// design and checker
	cfgmsg_if lk();
	cfg_responder i_cfg_responder (.core_clk(core_clk), .reset_n(reset_n), .lk(lk),
		.ps_valid(ps_valid), .ps_write(ps_write), .ps_num(ps_num), .ps_wdata(ps_wdata),
		.ps_rdata(ps_rdata), .ps_resource(ps_resource), .periph_wr(periph_wr),
		.periph_addr(periph_addr), .periph_wdata(periph_wdata));
	cfg_requester i_cfg_requester (.core_clk(core_clk), .reset_n(reset_n), .lk(lk),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
		.cmd_target(cmd_target), .cmd_periph(cmd_periph), .cmd_reply(cmd_reply),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_size(cmd_size),
		.res_done(res_done), .res_ok(res_ok), .res_rdata(res_rdata));
	cfgmsg_chk i_cfgmsg_chk (.core_clk(core_clk), .reset_n(reset_n),
		.req_valid(lk.req_valid), .req_ready(lk.req_ready), .req_ctrl(lk.req_ctrl),
		.req_data(lk.req_data), .req_dest(lk.req_dest), .rsp_valid(lk.rsp_valid),
		.rsp_ready(lk.rsp_ready), .rsp_ctrl(lk.rsp_ctrl), .rsp_data(lk.rsp_data),
		.rsp_dest(lk.rsp_dest));

	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;

	// ============================================================
	// helpers
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	function automatic logic [31:0] exp_resource(input logic [7:0] n);
		return ({24'h000000, n} << 8) | 32'h0000000C;
	endfunction

	task automatic chk_bit(input string name, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a wait that runs out counts as a mismatch and closes the run
	task automatic timed_out(input string name);
		error_cnt++;
		$display("unexpected %s expected done seen timeout", name);
		final_report();
	endtask

	task automatic ps_access(input logic w, input logic [7:0] n, input logic [31:0] d);
		ps_valid = 1'b1;
		ps_write = w;
		ps_num   = n;
		ps_wdata = d;
		@(negedge core_clk);
	endtask

	// one command through the requester; reply id bits 17:16 kept zero, cmd_periph left at zero for peripheral 0
	task automatic run_cmd(input cfgmsg_pkg::kind_e k, input logic [15:0] r,
		input logic [31:0] d, input logic [7:0] sz, input logic eok,
		input logic [31:0] erd, input logic cmp);
		int n;
		lfsr       = lfsr_step(lfsr);
		cmd_kind   = k;
		cmd_reg    = r;
		cmd_wdata  = d;
		cmd_size   = sz;
		cmd_target = lfsr[31:16];
		cmd_reply  = {lfsr[23:18], 2'b00, lfsr[15:0]};
		cmd_valid  = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 50)
			timed_out("cmd_ready");
		@(negedge core_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (res_done !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 100)
			timed_out("res_done");
		chk_bit("res_ok", eok, res_ok);
		if (eok && cmp)
			chk_word("res_rdata", erd, res_rdata);
	endtask

	// works out the answer from the shadow banks, then keeps them in step
	task automatic do_op(input cfgmsg_pkg::kind_e k, input logic [15:0] r,
		input logic [31:0] d, input logic [7:0] sz);
		int          b;
		logic        ok;
		logic        cmp;
		logic [31:0] e;
		b   = int'(r[7:0]) + int'(sz) - 4;
		ok  = r < 16'h0008;
		cmp = k == cfgmsg_pkg::K_TILE_RD || k == cfgmsg_pkg::K_NODE_RD;
		e   = (k == cfgmsg_pkg::K_TILE_RD) ? tile_m[r[2:0]] : node_m[r[2:0]];
		if (k == cfgmsg_pkg::K_PERIPH_RD) begin
			ok  = sz != 8'h00 && b + 4 <= 16;
			cmp = ok && b >= int'(r[7:0]);
			if (cmp)
				e = {pb_m[b], pb_m[b+1], pb_m[b+2], pb_m[b+3]};
		end
		run_cmd(k, r, d, sz, ok, e, cmp);
		if (ok && k == cfgmsg_pkg::K_TILE_WR)
			tile_m[r[2:0]] = d;
		if (ok && k == cfgmsg_pkg::K_NODE_WR)
			node_m[r[2:0]] = d;
	endtask

	// ============================================================
	// main sequence
	initial begin
		core_clk = 1'b0;
		reset_n  = 1'b0;
		{cmd_valid, ps_valid, ps_write, periph_wr} = 4'h0;
		{cmd_target, cmd_reg, cmd_periph, cmd_size, cmd_reply, cmd_wdata} = 104'h0;
		{ps_num, ps_wdata, periph_addr, periph_wdata} = 54'h0;
		cmd_kind = cmfg_kind_init();
		lfsr = 32'hF73E;
		error_cnt = 0;
		total_checks = 0;
		kt = '{cfgmsg_pkg::K_TILE_WR, cfgmsg_pkg::K_TILE_RD, cfgmsg_pkg::K_NODE_WR,
			cfgmsg_pkg::K_NODE_RD, cfgmsg_pkg::K_PERIPH_RD};
		for (i = 0; i < 8; i++) begin
			tile_m[i] = 32'h0;
			node_m[i] = 32'h0;
			ps_m[i]   = 32'h0;
		end
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		// status bank: read-before-write, number 8 is outside the bank
		for (i = 0; i < 9; i++) begin
			lfsr = lfsr_step(lfsr);
			v    = lfsr;
			ps_access(1'b1, 8'(i), v);
			chk_word("ps_rdata", (i < 8) ? ps_m[i[2:0]] : 32'h0, ps_rdata);
			chk_word("ps_resource", exp_resource(8'(i)), ps_resource);
			if (i < 8)
				ps_m[i[2:0]] = v;
			ps_access(1'b0, 8'(i), 32'h0);
			chk_word("ps_rdata", (i < 8) ? ps_m[i[2:0]] : 32'h0, ps_rdata);
		end
		ps_valid = 1'b0; // strobe held up across back to back accesses
		// peripheral 0 readable bytes, written back to back
		for (i = 0; i < 16; i++) begin
			lfsr         = lfsr_step(lfsr);
			periph_wr    = 1'b1;
			periph_addr  = {2'b00, i[3:0]};
			periph_wdata = lfsr[7:0];
			pb_m[i]      = lfsr[7:0];
			@(negedge core_clk);
		end
		periph_wr = 1'b0;
		// corners: refused write leaves the word alone, banks apart, size bounds
		do_op(cfgmsg_pkg::K_TILE_WR, 16'h0007, 32'hFFFFFFFF, 8'h00);
		do_op(cfgmsg_pkg::K_TILE_WR, 16'h0107, 32'h12345678, 8'h00);
		do_op(cfgmsg_pkg::K_TILE_RD, 16'h0007, 32'h0, 8'h00);
		do_op(cfgmsg_pkg::K_NODE_RD, 16'h0007, 32'h0, 8'h00);
		do_op(cfgmsg_pkg::K_PERIPH_RD, 16'h0000, 32'h0, 8'h10);
		do_op(cfgmsg_pkg::K_PERIPH_RD, 16'h000D, 32'h0, 8'h04);
		do_op(cfgmsg_pkg::K_PERIPH_RD, 16'h0005, 32'h0, 8'h00);
		// random mix, about half the register numbers out of range
		for (i = 0; i < 60; i++) begin
			lfsr = lfsr_step(lfsr);
			v    = lfsr_step(lfsr);
			do_op(kt[lfsr[2:0] % 5], (lfsr[7:4] == 4'hF) ? 16'h0103 :
				{12'h000, lfsr[11:8]}, v, {4'h0, lfsr[19:16]});
		end
		final_report();
	end

	function automatic cfgmsg_pkg::kind_e cmfg_kind_init();
		return cfgmsg_pkg::K_TILE_RD;
	endfunction
endmodule
